/* File: core/psrc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - writes to reg one only change bits whose capability-two bit is set.
// - writes to reg two only change bits whose capability-four bit is set.
// - register one bits 19..16 are read/write resets of timers 3..0.
// - reg one bit 14 resets two-wire unit 1, bit 12 unit 0; 15, 13 reserved.
// - register one bit 4 resets the sync serial unit; bit 3 is reserved.
// - register one bits 2..0 reset async serial units 2..0.
// - register two bit 13 resets the dma unit; other high bits read zero.
// - register two bits 4..0 reset io ports fifth..first.
// - every reset bit is cleared by system reset.
// - reserved bits are read-only zero; software keeps them when rewriting.
module psrc_ctrl
   import psrc_pkg::*;
(
   // clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     rst_n,
   input  wire logic                     clk_en,
   // capability masks from the system control block
   input  wire logic [31:0]              capability_mask_two,
   input  wire logic [31:0]              capability_mask_four,
   // axi4-lite write address
   input  wire logic [PSRC_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // axi4-lite read address
   input  wire logic [PSRC_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   // axi4-lite read data
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // unit reset outputs, active high while held
   output psrc_pkg::psrc_unit_resets_t   unit_resets
);
   import psrc_pkg::*;

   typedef enum logic [1:0] {
      PSRC_W_IDLE = 2'b00,
      PSRC_W_RESP = 2'b01
   } psrc_wstate_t;

   function automatic logic addr_hit(input logic [PSRC_ADDR_W-1:0] a,
                                     input logic [11:0] ofs);
      return a[PSRC_ADDR_W-1:2] == ofs[PSRC_ADDR_W-1:2];
   endfunction : addr_hit

   logic [31:0]        one_reg, one_next;
   logic [31:0]        two_reg, two_next;
   logic [31:0]        one_wr, two_wr;
   psrc_wstate_t       wst_reg, wst_next;
   logic               aw_got_reg, aw_got_next;
   logic               w_got_reg, w_got_next;
   logic [PSRC_ADDR_W-1:0] awa_reg, awa_next;
   logic [31:0]        wd_reg, wd_next;
   logic [3:0]         ws_reg, ws_next;
   logic               awr_reg, awr_next;
   logic               wr_reg, wr_next;
   logic               bv_reg, bv_next;
   logic [1:0]         br_reg, br_next;
   logic               arr_reg, arr_next;
   logic               rv_reg, rv_next;
   logic [31:0]        rd_reg, rd_next;
   logic [1:0]         rr_reg, rr_next;
   psrc_unit_resets_t  ur_reg, ur_next;

   psrc_mask_write u_mask_one (
      .old_val   (one_reg),
      .wr_data   (wd_reg),
      .wr_strb   (ws_reg),
      .impl_mask (PSRC_ONE_MASK),
      .cap_mask  (capability_mask_two),
      .new_val   (one_wr)
   );
   psrc_mask_write u_mask_two (
      .old_val   (two_reg),
      .wr_data   (wd_reg),
      .wr_strb   (ws_reg),
      .impl_mask (PSRC_TWO_MASK),
      .cap_mask  (capability_mask_four),
      .new_val   (two_wr)
   );

   // write channel: latch address and data in either order, then answer
   always_comb begin
      wst_next    = wst_reg;
      aw_got_next = aw_got_reg;
      w_got_next  = w_got_reg;
      awa_next    = awa_reg;
      wd_next     = wd_reg;
      ws_next     = ws_reg;
      awr_next    = awr_reg;
      wr_next     = wr_reg;
      bv_next     = bv_reg;
      br_next     = br_reg;
      one_next    = one_reg;
      two_next    = two_reg;
      case (wst_reg)
         PSRC_W_IDLE: begin
            awr_next = !aw_got_reg;
            wr_next  = !w_got_reg;
            if (s_axi_awvalid && awr_reg) begin
               aw_got_next = 1'b1;
               awa_next    = s_axi_awaddr;
               awr_next    = 1'b0;
            end
            if (s_axi_wvalid && wr_reg) begin
               w_got_next = 1'b1;
               wd_next    = s_axi_wdata;
               ws_next    = s_axi_wstrb;
               wr_next    = 1'b0;
            end
            if (aw_got_reg && w_got_reg) begin
               awr_next = 1'b0;
               wr_next  = 1'b0;
               br_next  = PSRC_RESP_OKAY;
               // reserved bits stay zero through the implemented mask
               if (addr_hit(awa_reg, PSRC_OFS_ONE)) begin
                  one_next = one_wr;
               end else if (addr_hit(awa_reg, PSRC_OFS_TWO)) begin
                  two_next = two_wr;
               end else if (!addr_hit(awa_reg, PSRC_OFS_CAP_TWO) &&
                            !addr_hit(awa_reg, PSRC_OFS_CAP_FOUR)) begin
                  br_next = PSRC_RESP_SLVERR;
               end
               bv_next  = 1'b1;
               wst_next = PSRC_W_RESP;
            end
         end
         PSRC_W_RESP: begin
            if (s_axi_bready) begin
               bv_next     = 1'b0;
               aw_got_next = 1'b0;
               w_got_next  = 1'b0;
               awr_next    = 1'b1;
               wr_next     = 1'b1;
               wst_next    = PSRC_W_IDLE;
            end
         end
         default: wst_next = PSRC_W_IDLE;
      endcase
   end

   // read channel: one outstanding read, data one cycle after address
   always_comb begin
      arr_next = arr_reg;
      rv_next  = rv_reg;
      rd_next  = rd_reg;
      rr_next  = rr_reg;
      if (rv_reg) begin
         if (s_axi_rready) begin
            rv_next  = 1'b0;
            arr_next = 1'b1;
         end
      end else if (s_axi_arvalid && arr_reg) begin
         arr_next = 1'b0;
         rv_next  = 1'b1;
         rr_next  = PSRC_RESP_OKAY;
         if (addr_hit(s_axi_araddr, PSRC_OFS_ONE))
            rd_next = one_reg;
         else if (addr_hit(s_axi_araddr, PSRC_OFS_TWO))
            rd_next = two_reg;
         else if (addr_hit(s_axi_araddr, PSRC_OFS_CAP_TWO))
            rd_next = capability_mask_two;
         else if (addr_hit(s_axi_araddr, PSRC_OFS_CAP_FOUR))
            rd_next = capability_mask_four;
         else begin
            rd_next = 32'h0000_0000;
            rr_next = PSRC_RESP_SLVERR;
         end
      end else begin
         // idle: offer the address channel again after reset or an answer
         arr_next = 1'b1;
      end
   end

   // unit resets follow the register bits level for level
   always_comb begin
      ur_next.timer        = one_next[PSRC_TIMER_LSB +: 4];
      ur_next.two_wire     = {one_next[PSRC_TWI1_BIT],
                              one_next[PSRC_TWI0_BIT]};
      ur_next.sync_serial  = one_next[PSRC_SSI_BIT];
      ur_next.async_serial = one_next[PSRC_ASYNC_LSB +: 3];
      ur_next.dma          = two_next[PSRC_DMA_BIT];
      ur_next.io_port      = two_next[PSRC_PORTA_BIT +: 5];
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         one_reg    <= PSRC_RESET_VAL;
         two_reg    <= PSRC_RESET_VAL;
         ur_reg     <= '0;
         wst_reg    <= PSRC_W_IDLE;
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         awa_reg    <= '0;
         wd_reg     <= 32'h0000_0000;
         ws_reg     <= 4'h0;
         awr_reg    <= 1'b0;
         wr_reg     <= 1'b0;
         bv_reg     <= 1'b0;
         br_reg     <= PSRC_RESP_OKAY;
         arr_reg    <= 1'b0;
         rv_reg     <= 1'b0;
         rd_reg     <= 32'h0000_0000;
         rr_reg     <= PSRC_RESP_OKAY;
      end else if (clk_en) begin
         one_reg    <= one_next;
         two_reg    <= two_next;
         ur_reg     <= ur_next;
         wst_reg    <= wst_next;
         aw_got_reg <= aw_got_next;
         w_got_reg  <= w_got_next;
         awa_reg    <= awa_next;
         wd_reg     <= wd_next;
         ws_reg     <= ws_next;
         awr_reg    <= awr_next;
         wr_reg     <= wr_next;
         bv_reg     <= bv_next;
         br_reg     <= br_next;
         arr_reg    <= arr_next;
         rv_reg     <= rv_next;
         rd_reg     <= rd_next;
         rr_reg     <= rr_next;
      end
   end

   assign s_axi_awready = awr_reg;
   assign s_axi_wready  = wr_reg;
   assign s_axi_bvalid  = bv_reg;
   assign s_axi_bresp   = br_reg;
   assign s_axi_arready = arr_reg;
   assign s_axi_rvalid  = rv_reg;
   assign s_axi_rdata   = rd_reg;
   assign s_axi_rresp   = rr_reg;
   assign unit_resets   = ur_reg;

   // assertions
   reserved_one_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (one_reg & ~PSRC_ONE_MASK) == 32'h0)
      else $error("reserved bit set in register one");
   reserved_two_zero_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (two_reg & ~PSRC_TWO_MASK) == 32'h0)
      else $error("reserved bit set in register two");
   cap_two_gate_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      clk_en && $stable(capability_mask_two) |=>
      (((one_reg ^ $past(one_reg)) & ~capability_mask_two) == 32'h0))
      else $error("absent unit bit changed in register one");
   cap_four_gate_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      clk_en && $stable(capability_mask_four) |=>
      (((two_reg ^ $past(two_reg)) & ~capability_mask_four) == 32'h0))
      else $error("absent unit bit changed in register two");
   timer_follow_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      unit_resets.timer == one_reg[19:16])
      else $error("timer resets do not follow register one");
   twi_ssi_follow_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      unit_resets.two_wire == {one_reg[14], one_reg[12]} &&
      unit_resets.sync_serial == one_reg[4])
      else $error("serial resets do not follow register one");
   uart_follow_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      unit_resets.async_serial == one_reg[2:0])
      else $error("async serial resets do not follow register one");
   port_dma_follow_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      unit_resets.io_port == two_reg[4:0] &&
      unit_resets.dma == two_reg[13])
      else $error("port or dma resets do not follow register two");
   reset_clear_a: assert property (
      @(posedge sys_clk) !rst_n |=> one_reg == 32'h0 && two_reg == 32'h0)
      else $error("reset bits not cleared by system reset");
   hold_stable_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !clk_en |=> $stable(unit_resets))
      else $error("unit resets moved while frozen");
endmodule : psrc_ctrl
`default_nettype wire

/* File: core/psrc_mask_write.sv */
`timescale 1ns/1ps
`default_nettype none
module psrc_mask_write (
   // old value and bus write
   input  wire logic [31:0] old_val,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  wr_strb,
   // implemented bits and capability gate
   input  wire logic [31:0] impl_mask,
   input  wire logic [31:0] cap_mask,
   // result
   output logic      [31:0] new_val
);
   logic [31:0] lane_mask;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_lane
         assign lane_mask[8*g +: 8] = {8{wr_strb[g]}};
      end
   endgenerate
   // only bits that exist, are present and are strobed take the new data
   always_comb begin
      logic [31:0] en;
      en = lane_mask & impl_mask & cap_mask;
      new_val = ((old_val & ~en) | (wr_data & en)) & impl_mask;
   end
endmodule : psrc_mask_write
`default_nettype wire

/* File: include/psrc_pkg.sv */
package psrc_pkg;
   // register byte addresses
   localparam logic [11:0] PSRC_OFS_ONE     = 12'h044;
   localparam logic [11:0] PSRC_OFS_TWO     = 12'h048;
   localparam logic [11:0] PSRC_OFS_CAP_TWO = 12'h04c;
   localparam logic [11:0] PSRC_OFS_CAP_FOUR = 12'h050;
   localparam int          PSRC_ADDR_W      = 12;
   localparam int          PSRC_DATA_W      = 32;
   localparam logic [31:0] PSRC_RESET_VAL   = 32'h0000_0000;
   // implemented (writable) bit masks
   localparam logic [31:0] PSRC_ONE_MASK    = 32'h000f_5017;
   localparam logic [31:0] PSRC_TWO_MASK    = 32'h0000_201f;
   // field positions, register one
   localparam int PSRC_TIMER_LSB  = 16;
   localparam int PSRC_TWI0_BIT   = 12;
   localparam int PSRC_TWI1_BIT   = 14;
   localparam int PSRC_SSI_BIT    = 4;
   localparam int PSRC_ASYNC_LSB  = 0;
   // field positions, register two
   localparam int PSRC_DMA_BIT    = 13;
   localparam int PSRC_PORTA_BIT  = 0;
   // capability defaults: all present (arbitrary plain defaults)
   localparam logic [31:0] PSRC_CAP_TWO_DEF  = 32'hffff_ffff;
   localparam logic [31:0] PSRC_CAP_FOUR_DEF = 32'hffff_ffff;
   // axi responses
   localparam logic [1:0] PSRC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] PSRC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] timer;
      logic [1:0] two_wire;
      logic       sync_serial;
      logic [2:0] async_serial;
      logic       dma;
      logic [4:0] io_port;
   } psrc_unit_resets_t;
endpackage : psrc_pkg

/* File: verif/psrc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module psrc_ctrl_tb;
   import psrc_pkg::*;
   // clock, reset and capability inputs
   logic              sys_clk  = 1'b0;
   logic              rst_n    = 1'b0;
   logic              clk_en   = 1'b1;
   logic [31:0]       cap_two  = 32'hffff_ffff;
   logic [31:0]       cap_four = 32'hffff_ffff;
   // bus master side
   logic [11:0]       awaddr   = 12'h000;
   logic              awvalid  = 1'b0;
   logic [31:0]       wdata    = 32'h0000_0000;
   logic [3:0]        wstrb    = 4'h0;
   logic              wvalid   = 1'b0;
   logic              bready   = 1'b0;
   logic [11:0]       araddr   = 12'h000;
   logic              arvalid  = 1'b0;
   logic              rready   = 1'b0;
   logic              awready;
   logic              wready;
   logic [1:0]        bresp;
   logic              bvalid;
   logic              arready;
   logic [31:0]       rdata;
   logic [1:0]        rresp;
   logic              rvalid;
   psrc_unit_resets_t ures;
   int                n_mismatch = 0;
   int                n_tests    = 0;

   psrc_ctrl u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .capability_mask_two(cap_two), .capability_mask_four(cap_four),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .unit_resets(ures));

   always #4 sys_clk = ~sys_clk;

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // write one word; address and data offered together, each dropped when taken
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
           input logic [1:0] exp_r);
      bit aw_ok;
      bit w_ok;
      bit b_ok;
      int n;
      aw_ok = 0;
      w_ok  = 0;
      b_ok  = 0;
      n     = 0;
      @(posedge sys_clk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!b_ok && n < 200) begin
         @(posedge sys_clk);
         n++;
         if (bvalid && aw_ok && w_ok) begin
            chk("bresp", {30'h0, exp_r}, {30'h0, bresp});
            bready <= 1'b0;
            b_ok = 1;
         end
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            aw_ok = 1;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            w_ok = 1;
         end
      end
      if (!b_ok) chk("write answer", 32'h1, 32'h0);
   endtask : wr

   task rd(input logic [11:0] a, input logic [31:0] exp_d,
           input logic [1:0] exp_r);
      bit r_ok;
      int n;
      r_ok = 0;
      n    = 0;
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!r_ok && n < 200) begin
         @(posedge sys_clk);
         n++;
         if (rvalid) begin
            chk("rdata", exp_d, rdata);
            chk("rresp", {30'h0, exp_r}, {30'h0, rresp});
            rready <= 1'b0;
            r_ok = 1;
         end
         if (arvalid && arready) arvalid <= 1'b0;
      end
      if (!r_ok) chk("read answer", 32'h1, 32'h0);
   endtask : rd

   task uchk(input logic [15:0] exp);
      chk("unit_resets", {16'h0, exp}, {16'h0, ures});
   endtask : uchk

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // the whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge sys_clk);
      rst_n <= 1'b1;
      uchk(16'h0000);
      rd(12'h044, 32'h0000_0000, 2'h0);
      rd(12'h048, 32'h0000_0000, 2'h0);
      $display("test reset values done");
      wr(12'h044, 32'h0004_4002, 4'hf, 2'h0);
      rd(12'h044, 32'h0004_4002, 2'h0);
      uchk(16'h4880);
      wr(12'h044, 32'h0000_1010, 4'hf, 2'h0);
      uchk(16'h0600);
      wr(12'h044, 32'hffff_ffff, 4'hf, 2'h0);
      rd(12'h044, 32'h000f_5017, 2'h0);
      uchk(16'hffc0);
      wr(12'h048, 32'hffff_ffff, 4'hf, 2'h0);
      rd(12'h048, 32'h0000_201f, 2'h0);
      uchk(16'hffff);
      wr(12'h048, 32'h0000_0005, 4'hf, 2'h0);
      uchk(16'hffc5);
      wr(12'h044, 32'h0000_0000, 4'hf, 2'h0);
      wr(12'h048, 32'h0000_0000, 4'hf, 2'h0);
      uchk(16'h0000);
      $display("test field map done");
      cap_two <= 32'h000a_0001;
      wr(12'h044, 32'hffff_ffff, 4'hf, 2'h0);
      rd(12'h044, 32'h000a_0001, 2'h0);
      cap_two <= 32'h0000_0001;
      wr(12'h044, 32'h0000_0000, 4'hf, 2'h0);
      rd(12'h044, 32'h000a_0000, 2'h0);
      rd(12'h04c, 32'h0000_0001, 2'h0);
      cap_four <= 32'h0000_2000;
      wr(12'h048, 32'hffff_ffff, 4'hf, 2'h0);
      rd(12'h048, 32'h0000_2000, 2'h0);
      uchk(16'ha020);
      cap_two  <= 32'hffff_ffff;
      cap_four <= 32'hffff_ffff;
      wr(12'h044, 32'h0000_0000, 4'hf, 2'h0);
      wr(12'h048, 32'h0000_0000, 4'hf, 2'h0);
      $display("test capability gate done");
      // only lane two strobed: the timer bits change, the rest stays clear
      wr(12'h044, 32'hffff_ffff, 4'h4, 2'h0);
      rd(12'h044, 32'h000f_0000, 2'h0);
      // ones into every reserved bit, timer bits kept set
      wr(12'h044, 32'hffff_afe8, 4'hf, 2'h0);
      rd(12'h044, 32'h000f_0000, 2'h0);
      rd(12'h100, 32'h0000_0000, 2'h2);
      wr(12'h100, 32'hffff_ffff, 4'hf, 2'h2);
      wr(12'h04c, 32'h0000_0000, 4'hf, 2'h0);
      rd(12'h04c, 32'hffff_ffff, 2'h0);
      rd(12'h044, 32'h000f_0000, 2'h0);
      $display("test strobes and refusals done");
      // freeze after the handshakes: the commit must wait for clk_en
      fork
         wr(12'h048, 32'h0000_0001, 4'hf, 2'h0);
         begin
            repeat (2) @(posedge sys_clk);
            clk_en <= 1'b0;
            repeat (5) @(posedge sys_clk);
            chk("frozen unit_resets", 32'h0000_f000, {16'h0, ures});
            clk_en <= 1'b1;
         end
      join
      uchk(16'hf001);
      $display("test clock enable freeze done");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      uchk(16'h0000);
      rst_n <= 1'b1;
      rd(12'h044, 32'h0000_0000, 2'h0);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : psrc_ctrl_tb
`default_nettype wire
